// ===== hdl/dpwm_map.vh
/*
 register offsets, field positions, reset values and timing counts for the dual pwm timer unit.
 assumes an 8-bit register port (address, write strobe, data in/out) driven on mclk.
*/
// Summary of operation
// R01: two enableable pwm channels, own registers, 10-bit
// R02: outputs held off until configuration load done
// R03: bus loss after four schedules forces defaults
// R04: remote node must send messages often enough
// R05: 8-bit timer, readable, cleared on reset/off
// R06: timer clock mclk/4, prescale 1/4/16
// R07: timer counts from zero up to period
// R08: reset sets period registers to all ones
// R09: timer_on_bit at bit 7 enables timer
// R10: prescaler cleared on control/count write, reset
// R11: period equals (limit+1) times 4 times prescale
// R12: after match clear timer, latch duty slave
// R13: duty is master byte plus two low bits
// R14: master writable anytime, applied at period end
// R15: pin cleared when duty equals extended count
// R16: duty beyond period keeps output high
// R17: pin set at period start unless duty zero
// R18: option bit 2 enables bus-loss default
`ifndef DPWM_MAP_VH
`define DPWM_MAP_VH
`define DPWM_ADDR_W 8
`define DPWM_TCON1_ADDR 8'h05
`define DPWM_TCON2_ADDR 8'h06
`define DPWM_PR1_ADDR 8'h07
`define DPWM_PR2_ADDR 8'h08
`define DPWM_DCH1_ADDR 8'h09
`define DPWM_DCH2_ADDR 8'h0a
`define DPWM_TMR1_ADDR 8'h0b
`define DPWM_TMR2_ADDR 8'h0c
`define DPWM_OPT2_ADDR 8'h0d
`define DPWM_ON_BIT 7
`define DPWM_PS_HI 5
`define DPWM_PS_LO 4
`define DPWM_DCL_HI 1
`define DPWM_DCL_LO 0
`define DPWM_TCON_MASK 8'hb3
`define DPWM_PDEF_BIT 2
`define DPWM_PR_RESET 8'hff
`define DPWM_ZERO8 8'h00
`define DPWM_ZERO2 2'h0
`define DPWM_ONE8 8'h01
`define DPWM_ONE4 4'h1
`define DPWM_PS_DIV1 2'h0
`define DPWM_PS_DIV4 2'h1
`define DPWM_LOSS_LIMIT 3'h4
`define DPWM_ONE3 3'h1
`define DPWM_QTICK_PRE 2'h2
`endif

// ===== hdl/dpwm_channel.v
/*
 one pwm channel: prescaler, 8-bit timer, double-buffered 10-bit duty compare.
 assumes qtick is a one-cycle pulse at mclk/4 and q_phase the quarter-cycle phase.
*/
`timescale 1ns/1ps
`include "dpwm_map.vh"
module dpwm_channel (
    input wire mclk,
    input wire rst,
    input wire qtick,
    input wire [1:0] q_phase,
    input wire run,
    input wire [1:0] prescale_sel,
    input wire [7:0] period_limit,
    input wire [9:0] duty_master,
    input wire tmr_wr,
    input wire ctl_wr,
    input wire [7:0] wr_data,
    output reg [7:0] pwm_timer_count,
    output reg pwm_out
);
    reg [3:0] ps_cnt;
    reg [7:0] duty_slave_high;
    reg [1:0] duty_low_bits;
    wire [3:0] ps_top;
    wire tmr_tick;
    wire [1:0] sub_bits;
    wire [9:0] ext_count;
    wire period_match;
    reg period_start;
    // divide-by-1/4/16 terminal counts
    assign ps_top = (prescale_sel == `DPWM_PS_DIV1) ? 4'h0 :
                    (prescale_sel == `DPWM_PS_DIV4) ? 4'h3 : 4'hf; // [R06]
    assign tmr_tick = run & qtick & (ps_cnt == ps_top);
    // low compare bits come from the quarter clock at 1:1, else the prescaler
    assign sub_bits = (prescale_sel == `DPWM_PS_DIV1) ? q_phase :
                      (prescale_sel == `DPWM_PS_DIV4) ? ps_cnt[1:0] : ps_cnt[3:2]; // [R15]
    assign ext_count = {pwm_timer_count, sub_bits};
    // a count write wins over the match in the same cycle
    assign period_match = tmr_tick & ~tmr_wr & (pwm_timer_count == period_limit);

    always @(posedge mclk) begin
        if (rst || ctl_wr || tmr_wr || !run) begin
            ps_cnt <= 4'h0; // [R10]
        end else if (qtick) begin
            ps_cnt <= (ps_cnt == ps_top) ? 4'h0 : ps_cnt + `DPWM_ONE4;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            pwm_timer_count <= `DPWM_ZERO8; // [R05]
            duty_slave_high <= `DPWM_ZERO8;
            duty_low_bits <= `DPWM_ZERO2;
        end else if (!run) begin
            pwm_timer_count <= `DPWM_ZERO8; // [R05]
        end else if (tmr_wr) begin
            pwm_timer_count <= wr_data;
        end else if (period_match) begin
            pwm_timer_count <= `DPWM_ZERO8; // [R07] [R11] [R12]
            duty_slave_high <= duty_master[9:2]; // [R12] [R14]
            duty_low_bits <= duty_master[1:0]; // [R13]
        end else if (tmr_tick) begin
            pwm_timer_count <= pwm_timer_count + `DPWM_ONE8; // [R07]
        end
    end

    // set one cycle after the match so the registered clear gives exactly
    // duty steps of high time; the match cycle itself still compares
    always @(posedge mclk) begin
        if (rst || !run) begin
            period_start <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            period_start <= period_match;
            if (period_start) begin
                pwm_out <= ({duty_slave_high, duty_low_bits} != 10'h000); // [R17]
            end else if ({duty_slave_high, duty_low_bits} == ext_count) begin
                // a duty beyond the period never matches, so the pin stays high
                pwm_out <= 1'b0; // [R15] [R16]
            end
        end
    end
endmodule // dpwm_channel

// ===== hdl/dpwm_top.v
/*
 dual pwm timer unit: register file, quarter clock divider, bus-loss fallback, two channels.
 assumes register accesses and status strobes come from logic on mclk; only
 the configuration-done level is treated as same-domain too.
*/
`timescale 1ns/1ps
`include "dpwm_map.vh"
module dpwm_top (
    input wire mclk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire config_done,
    input wire rx_valid_msg,
    input wire sched_tx,
    output reg pwm1_pin,
    output reg pwm1_pin_oe,
    output reg pwm2_pin,
    output reg pwm2_pin_oe,
    output reg comm_lost
);
    reg [7:0] timer1_control;
    reg [7:0] timer2_control;
    reg [7:0] period1_limit;
    reg [7:0] period2_limit;
    reg [7:0] duty1_high_byte;
    reg [7:0] duty2_high_byte;
    reg [7:0] option_config_two;
    reg [1:0] q_phase;
    reg qtick;
    reg [2:0] miss_cnt;
    reg cfg_loaded;
    wire [7:0] count1;
    wire [7:0] count2;
    wire out1;
    wire out2;
    wire run1;
    wire run2;
    wire [7:0] next_rdata;
    wire comm_loss_default_enable;

    assign comm_loss_default_enable = option_config_two[`DPWM_PDEF_BIT]; // [R18]
    assign run1 = cfg_loaded & ~comm_lost & timer1_control[`DPWM_ON_BIT]; // [R01] [R09]
    assign run2 = cfg_loaded & ~comm_lost & timer2_control[`DPWM_ON_BIT]; // [R01] [R09]

    always @(posedge mclk) begin
        if (rst) begin
            q_phase <= 2'h0;
            qtick <= 1'b0;
        end else begin
            q_phase <= q_phase + 2'h1;
            // tick lands as the phase wraps, so {count, phase} steps in order
            qtick <= (q_phase == `DPWM_QTICK_PRE); // [R06]
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            cfg_loaded <= 1'b0;
        end else if (config_done) begin
            cfg_loaded <= 1'b1; // [R02]
        end
    end

    // a valid message wins over a schedule in the same cycle
    always @(posedge mclk) begin
        if (rst) begin
            miss_cnt <= 3'h0;
            comm_lost <= 1'b0;
        end else if (rx_valid_msg || !comm_loss_default_enable) begin
            miss_cnt <= 3'h0;
        end else if (sched_tx && miss_cnt != `DPWM_LOSS_LIMIT) begin
            miss_cnt <= miss_cnt + `DPWM_ONE3;
            if (miss_cnt + `DPWM_ONE3 == `DPWM_LOSS_LIMIT) begin
                comm_lost <= 1'b1; // [R03]
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            timer1_control <= `DPWM_ZERO8;
            timer2_control <= `DPWM_ZERO8;
            period1_limit <= `DPWM_PR_RESET; // [R08]
            period2_limit <= `DPWM_PR_RESET; // [R08]
            duty1_high_byte <= `DPWM_ZERO8;
            duty2_high_byte <= `DPWM_ZERO8;
            option_config_two <= `DPWM_ZERO8;
        end else if (comm_lost) begin
            // fallback restores the control and period defaults and disables both channels; duty registers keep their values, option stays writable
            timer1_control <= `DPWM_ZERO8; // [R03]
            timer2_control <= `DPWM_ZERO8;
            period1_limit <= `DPWM_PR_RESET;
            period2_limit <= `DPWM_PR_RESET;
            if (reg_wr && reg_addr == `DPWM_OPT2_ADDR) begin
                option_config_two <= reg_wdata;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `DPWM_TCON1_ADDR: timer1_control <= reg_wdata & `DPWM_TCON_MASK;
                `DPWM_TCON2_ADDR: timer2_control <= reg_wdata & `DPWM_TCON_MASK;
                `DPWM_PR1_ADDR: period1_limit <= reg_wdata;
                `DPWM_PR2_ADDR: period2_limit <= reg_wdata;
                `DPWM_DCH1_ADDR: duty1_high_byte <= reg_wdata; // [R14]
                `DPWM_DCH2_ADDR: duty2_high_byte <= reg_wdata; // [R14]
                `DPWM_OPT2_ADDR: option_config_two <= reg_wdata;
                default: ;
            endcase
        end
    end

    assign next_rdata = (reg_addr == `DPWM_TCON1_ADDR) ? timer1_control :
                        (reg_addr == `DPWM_TCON2_ADDR) ? timer2_control :
                        (reg_addr == `DPWM_PR1_ADDR) ? period1_limit :
                        (reg_addr == `DPWM_PR2_ADDR) ? period2_limit :
                        (reg_addr == `DPWM_DCH1_ADDR) ? duty1_high_byte :
                        (reg_addr == `DPWM_DCH2_ADDR) ? duty2_high_byte :
                        (reg_addr == `DPWM_TMR1_ADDR) ? count1 :
                        (reg_addr == `DPWM_TMR2_ADDR) ? count2 :
                        (reg_addr == `DPWM_OPT2_ADDR) ? option_config_two : `DPWM_ZERO8;

    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= `DPWM_ZERO8;
            pwm1_pin <= 1'b0;
            pwm2_pin <= 1'b0;
            pwm1_pin_oe <= 1'b0;
            pwm2_pin_oe <= 1'b0;
        end else begin
            reg_rdata <= next_rdata; // [R05]
            pwm1_pin <= out1 & run1;
            pwm2_pin <= out2 & run2;
            // pins stay driven once configured; undriven before then
            pwm1_pin_oe <= cfg_loaded; // [R02]
            pwm2_pin_oe <= cfg_loaded;
        end
    end

    dpwm_channel u_ch1 (
        .mclk(mclk),
        .rst(rst),
        .qtick(qtick),
        .q_phase(q_phase),
        .run(run1),
        .prescale_sel(timer1_control[`DPWM_PS_HI:`DPWM_PS_LO]),
        .period_limit(period1_limit),
        .duty_master({duty1_high_byte, timer1_control[`DPWM_DCL_HI:`DPWM_DCL_LO]}),
        .tmr_wr(reg_wr && !comm_lost && reg_addr == `DPWM_TMR1_ADDR),
        .ctl_wr(reg_wr && reg_addr == `DPWM_TCON1_ADDR), // [R10]
        .wr_data(reg_wdata),
        .pwm_timer_count(count1),
        .pwm_out(out1)
    );

    dpwm_channel u_ch2 (
        .mclk(mclk),
        .rst(rst),
        .qtick(qtick),
        .q_phase(q_phase),
        .run(run2),
        .prescale_sel(timer2_control[`DPWM_PS_HI:`DPWM_PS_LO]),
        .period_limit(period2_limit),
        .duty_master({duty2_high_byte, timer2_control[`DPWM_DCL_HI:`DPWM_DCL_LO]}),
        .tmr_wr(reg_wr && !comm_lost && reg_addr == `DPWM_TMR2_ADDR),
        .ctl_wr(reg_wr && reg_addr == `DPWM_TCON2_ADDR), // [R10]
        .wr_data(reg_wdata),
        .pwm_timer_count(count2),
        .pwm_out(out2)
    );
endmodule // dpwm_top

// ===== sim/dpwm_properties.sv
/*
 checker for dpwm_top: pin enables, bus-loss fallback, register read values.
 assumes it is bound to dpwm_top and sees only its ports.
*/
`timescale 1ns/1ps
module dpwm_properties (
    input wire mclk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire config_done,
    input wire rx_valid_msg,
    input wire sched_tx,
    input wire pwm1_pin,
    input wire pwm1_pin_oe,
    input wire pwm2_pin,
    input wire pwm2_pin_oe,
    input wire comm_lost
);
    reg cfg_seen;
    reg loss_en;
    reg on1;
    reg [2:0] miss_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always @(posedge mclk) begin
        if (rst) begin
            cfg_seen <= 1'b0;
            loss_en <= 1'b0;
            on1 <= 1'b0;
            miss_cnt <= 3'h0;
        end else begin
            cfg_seen <= cfg_seen | config_done;
            if (reg_wr && reg_addr == 8'h0d)
                loss_en <= reg_wdata[2];
            // forced control defaults stop the timer too
            if (comm_lost)
                on1 <= 1'b0;
            else if (reg_wr && reg_addr == 8'h05)
                on1 <= reg_wdata[7];
            if (rx_valid_msg || !loss_en)
                miss_cnt <= 3'h0;
            else if (sched_tx && loss_en && miss_cnt != 3'h4)
                miss_cnt <= miss_cnt + 3'h1;
        end
    end
    a_pins_held_off:
        assert property (!cfg_seen |-> !pwm1_pin_oe && !pwm2_pin_oe && !pwm1_pin && !pwm2_pin)
        else $error("pin active before configuration");
    a_oe_after_cfg:
        assert property ($rose(cfg_seen) |-> ##[0:2] (pwm1_pin_oe && pwm2_pin_oe))
        else $error("pins not enabled after configuration");
    a_loss_sticky:
        assert property (comm_lost |=> comm_lost)
        else $error("loss flag dropped");
    a_loss_low:
        assert property (comm_lost && $past(comm_lost) |-> !pwm1_pin && !pwm2_pin)
        else $error("pins not default on loss");
    a_loss_cause:
        assert property ($rose(comm_lost) |-> $past(loss_en) && miss_cnt == 3'h4)
        else $error("loss without four misses");
    a_loss_fires:
        assert property (loss_en && miss_cnt == 3'h4 |-> ##[0:2] comm_lost)
        else $error("loss not raised");
    a_ctrl_unimpl:
        assert property ($past(reg_addr) == 8'h05 |-> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'h0)
        else $error("control unused bits set");
    a_tmr_off_zero:
        assert property (!on1 && !$past(on1) && !$past(on1, 2) && $past(reg_addr) == 8'h0b |-> reg_rdata == 8'h00)
        else $error("stopped timer not zero");
endmodule // dpwm_properties
bind dpwm_top dpwm_properties u_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .config_done(config_done), .rx_valid_msg(rx_valid_msg),
    .sched_tx(sched_tx), .pwm1_pin(pwm1_pin), .pwm1_pin_oe(pwm1_pin_oe), .pwm2_pin(pwm2_pin),
    .pwm2_pin_oe(pwm2_pin_oe), .comm_lost(comm_lost));

// ===== sim/dpwm_load.sv
/*
 load on one pwm pin, with a pull-down; reports the wire level.
 assumes pin and enable come straight from the device.
*/
`timescale 1ns/1ps
module dpwm_load (
    input wire pin,
    input wire pin_oe,
    output wire level
);
    // a released pin is pulled low, never left at its last value
    assign level = pin_oe ? pin : 1'b0;
endmodule // dpwm_load

// ===== sim/tb_top.sv
/*
 self-checking bench for dpwm_top: registers, duty and period per channel, bus-loss fallback.
 assumes dpwm_top, dpwm_load and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "dpwm_map.vh"
module tb_top;
    reg mclk, rst, reg_wr, config_done, rx_valid_msg, sched_tx;
    reg [7:0] reg_addr, reg_wdata, rv, pr, ch;
    reg [9:0] dv;
    wire [7:0] reg_rdata;
    wire pwm1_pin, pwm1_pin_oe, pwm2_pin, pwm2_pin_oe, comm_lost;
    wire [1:0] level;
    integer failures, compares, cycles, seed, i, hi, pf, per;
    dpwm_top u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .config_done(config_done), .rx_valid_msg(rx_valid_msg), .sched_tx(sched_tx),
        .pwm1_pin(pwm1_pin), .pwm1_pin_oe(pwm1_pin_oe), .pwm2_pin(pwm2_pin), .pwm2_pin_oe(pwm2_pin_oe),
        .comm_lost(comm_lost));
    dpwm_load u_load1 (.pin(pwm1_pin), .pin_oe(pwm1_pin_oe), .level(level[0]));
    dpwm_load u_load2 (.pin(pwm2_pin), .pin_oe(pwm2_pin_oe), .level(level[1]));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    // high cycles in one period; duty past the period saturates
    function integer exp_high(input integer d, input integer f, input integer p);
        exp_high = (d * f > p) ? p : d * f;
    endfunction
    task chk(input ok, input string m);
        begin
            compares = compares + 1;
            if (!ok) begin
                failures = failures + 1;
                $display("MISMATCH %0t %s", $time, m);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_wdata = v;
            reg_wr = 1'b1;
            @(negedge mclk);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge mclk);
            reg_addr = a;
            @(negedge mclk);
            rv = reg_rdata;
        end
    endtask
    task pulse(input s);
        begin
            @(negedge mclk);
            sched_tx = s;
            rx_valid_msg = !s;
            @(negedge mclk);
            sched_tx = 1'b0;
            rx_valid_msg = 1'b0;
        end
    endtask
    task do_reset(input integer n);
        begin
            rst = 1'b1;
            repeat (n) @(negedge mclk);
            rst = 1'b0;
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        seed = 32'hf7c6;
        failures = 0;
        compares = 0;
        cycles = 0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        config_done = 1'b0;
        rx_valid_msg = 1'b0;
        sched_tx = 1'b0;
        do_reset(12);
        rd(`DPWM_PR2_ADDR);
        chk(rv === 8'hff, "period reset");
        rd(8'h3f);
        chk(rv === 8'h00, "unmapped read");
        wr(`DPWM_TCON1_ADDR, 8'h80);
        wr(`DPWM_DCH1_ADDR, 8'h01);
        repeat (40) @(negedge mclk);
        chk(level === 2'b00 && pwm1_pin_oe === 1'b0, "pins before config");
        config_done = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            ch = {7'h00, i[2]};
            pr = ($random(seed) & 8'h0f) + 8'h01;
            dv = (i == 4) ? 10'h000 : (i == 5) ? 10'h3ff : {$random(seed)} % (pr * 4 + 8);
            pf = (i[1:0] == 2'h0) ? 1 : (i[1:0] == 2'h1) ? 4 : 16;
            per = (pr + 1) * 4 * pf;
            // stop first: a count left above the new period would wrap through 255
            wr(`DPWM_TCON1_ADDR + ch, 8'h00);
            wr(`DPWM_PR1_ADDR + ch, pr);
            wr(`DPWM_DCH1_ADDR + ch, dv[9:2]);
            wr(`DPWM_TCON1_ADDR + ch, {2'h2, i[1:0], 2'h0, dv[1:0]});
            repeat (3 * per) @(negedge mclk);
            hi = 0;
            repeat (per) @(negedge mclk) hi = hi + level[ch[0]];
            chk(hi === exp_high(dv, pf, per), "high time");
            rd(`DPWM_TMR1_ADDR + ch);
            chk((rv <= pr) === 1'b1, "count past period");
        end
        wr(`DPWM_TCON1_ADDR, 8'h00);
        repeat (4) @(negedge mclk);
        rd(`DPWM_TMR1_ADDR);
        chk(rv === 8'h00, "stopped timer");
        repeat (6) pulse(1'b1);
        chk(comm_lost === 1'b0, "loss while disabled");
        pulse(1'b0);
        wr(`DPWM_OPT2_ADDR, 8'h04);
        repeat (3) pulse(1'b1);
        pulse(1'b0);
        repeat (3) pulse(1'b1);
        chk(comm_lost === 1'b0, "early loss");
        pulse(1'b1);
        repeat (2) @(negedge mclk);
        chk(comm_lost === 1'b1, "no loss after four");
        wr(`DPWM_PR2_ADDR, 8'h10);
        rd(`DPWM_PR2_ADDR);
        chk(rv === 8'hff && level === 2'b00, "defaults on loss");
        do_reset(3);
        chk(comm_lost === 1'b0, "loss after reset");
        tally_and_finish;
    end
endmodule // tb_top
